// File: design/cswt_timers.sv
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module cswt_timers #(
	parameter int NUM_WAKE = 3,
	parameter int NUM_HS = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] addr,
	input wire logic [15:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [15:0] rdData,
	// device context
	input wire cswt_pkg::cswt_mode_t mode,
	input wire logic sleepReq,
	input wire logic [2:0] wakeInput,
	input wire logic [3:0] hsFault,
	// outputs
	output logic [3:0] highsideSwitch,
	output logic intReq_n,
	output logic wakeRequest
);
	import cswt_pkg::*;

	// mode decode
	logic failSafe;
	logic awakeMode;
	assign failSafe = (mode == MODE_FAILSAFE);
	assign awakeMode = (mode == MODE_NORMAL) || (mode == MODE_STOP);

	// software registers
	logic [5:0] setup_reg [0:1]; // period and on-time per timer
	logic [3:0] mapA_reg; // switches 0 and 1
	logic [3:0] mapB_reg; // switches 2 and 3
	logic [10:0] src_reg; // wake sources
	logic [2:0] flagsA_reg; // per-input wake flags
	logic [1:0] flagsB_reg; // timer wake flags
	logic [2:0] snap_reg; // wake level snapshot
	logic spiFail_reg; // on-time longer than period
	logic [3:0] hsOff_reg; // switch shut by fault
	logic [7:0] hsMap;
	assign hsMap = {mapB_reg, mapA_reg};

	// shared 0.1 ms time base
	logic [9:0] pre_reg;
	logic tick;
	assign tick = (pre_reg == 10'(TICK_CYC - 1));
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_reg <= 10'h000;
		end else if (tick) begin
			pre_reg <= 10'h000;
		end else begin
			pre_reg <= pre_reg + 10'h001;
		end
	end

	// timer state
	logic [14:0] cnt_reg [0:1];
	logic [1:0] run_reg;
	logic [1:0] onPhase; // inside on-time
	logic [1:0] onStart; // this tick starts on-time
	logic [1:0] onEnd; // on-time finishes this tick
	logic [1:0] tmrLvl; // level to a mapped switch
	logic [1:0] tooLong; // on-time exceeds period
	logic [1:0] tmrWake;

	genvar t;
	generate
		for (t = 0; t < 2; t++) begin : gTimer
			logic [2:0] perSel;
			logic [2:0] onSel;
			logic [14:0] per;
			logic [14:0] onT;
			logic wrMe;
			assign perSel = setup_reg[t][SETUP_PERIOD_LSB +: 3];
			assign onSel = setup_reg[t][SETUP_ONTIME_LSB +: 3];
			assign per = PERIOD_TICKS[perSel];
			assign onT = ONTIME_TICKS[onSel];
			assign wrMe = wrStb && (addr == ((t == 0) ? OFF_FIRST_TIMER_SETUP : OFF_SECOND_TIMER_SETUP));

			// setup register, written by software
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					setup_reg[t] <= SETUP_RESET;
				end else if (wrMe) begin
					setup_reg[t] <= wrData[5:0];
				end
			end

			// counter restarts at the on-time on every running write
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					run_reg[t] <= 1'b0;
					cnt_reg[t] <= 15'h0000;
				end else if (failSafe) begin
					run_reg[t] <= 1'b0;
					cnt_reg[t] <= 15'h0000;
				end else if (wrMe) begin
					run_reg[t] <= (wrData[SETUP_ONTIME_LSB +: 3] >= ON_FIRST_RUN);
					cnt_reg[t] <= 15'h0000;
				end else if (run_reg[t] && tick) begin
					// no fault input stops it
					cnt_reg[t] <= (cnt_reg[t] >= per - 15'h0001) ? 15'h0000 : cnt_reg[t] + 15'h0001;
				end
			end

			assign onPhase[t] = run_reg[t] && (cnt_reg[t] < onT);
			assign onStart[t] = run_reg[t] && tick && (cnt_reg[t] >= per - 15'h0001);
			assign onEnd[t] = run_reg[t] && tick && (cnt_reg[t] == onT - 15'h0001);
			assign tmrLvl[t] = run_reg[t] ? onPhase[t] : (onSel == ON_OFF_HIGH);
			assign tooLong[t] = run_reg[t] && (onT > per);
			// first on-time is begun by the write itself, so no start event
			assign tmrWake[t] = onStart[t] && src_reg[SRC_TIMER_WAKE_LSB + t] && awakeMode;
		end
	endgenerate

	// wake input synchronisers and filtered level
	logic [2:0] sy1_reg;
	logic [2:0] sy2_reg;
	logic [2:0] sy3_reg;
	logic [2:0] lvl_reg; // accepted pin level
	logic [2:0] lvlPrev_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sy1_reg <= 3'h0;
			sy2_reg <= 3'h0;
			sy3_reg <= 3'h0;
			lvl_reg <= 3'h0;
			lvlPrev_reg <= 3'h0;
		end else begin
			sy1_reg <= wakeInput;
			sy2_reg <= sy1_reg;
			sy3_reg <= sy2_reg;
			lvl_reg <= (sy2_reg & sy3_reg) | (lvl_reg & (sy2_reg ^ sy3_reg));
			lvlPrev_reg <= lvl_reg;
		end
	end

	// cyclic sampling per wake input
	logic [2:0] cycOn; // input under cyclic sensing
	logic [2:0] sampDone; // stable sample accepted
	logic [2:0] smp_reg;
	logic [2:0] ref_reg;
	logic [2:0] refOk_reg;
	logic [2:0] cycEvt;
	logic [2:0] statEvt;
	genvar i;
	generate
		for (i = 0; i < NUM_WAKE; i++) begin : gWake
			cswt_filt_t st_reg;
			logic [7:0] fc_reg;
			logic [1:0] sel;
			logic endHit;
			assign sel = src_reg[2 * i +: 2];
			// fail-safe drops back to static sensing
			assign cycOn[i] = (sel != 2'h0) && !failSafe && run_reg[sel[1]];
			assign endHit = cycOn[i] && onEnd[sel[1]];
			assign sampDone[i] = (st_reg == FILT_WAIT) && (lvl_reg[i] == smp_reg[i]) &&
				(fc_reg == 8'(WAKE_FILTER_WINDOW_CYC - 1));
			assign cycEvt[i] = sampDone[i] && cycOn[i] && refOk_reg[i] && (smp_reg[i] != ref_reg[i]);
			assign statEvt[i] = !cycOn[i] && (src_reg[SRC_STATIC_LSB + i] || failSafe) &&
				(lvl_reg[i] != lvlPrev_reg[i]);

			// window starts at the on-time end and must see a steady level
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					st_reg <= FILT_IDLE;
					fc_reg <= 8'h00;
					smp_reg[i] <= 1'b0;
					ref_reg[i] <= 1'b0;
					refOk_reg[i] <= 1'b0;
				end else if (!cycOn[i]) begin
					st_reg <= FILT_IDLE;
					refOk_reg[i] <= 1'b0;
				end else begin
					unique case (st_reg)
						FILT_IDLE: begin
							if (endHit) begin
								st_reg <= FILT_WAIT;
								fc_reg <= 8'h00;
								smp_reg[i] <= lvl_reg[i];
							end
						end
						FILT_WAIT: begin
							if (lvl_reg[i] != smp_reg[i]) begin
								st_reg <= FILT_IDLE; // transient, sample dropped
							end else if (sampDone[i]) begin
								st_reg <= FILT_IDLE;
								ref_reg[i] <= smp_reg[i]; // reference for next cycle
								refOk_reg[i] <= 1'b1;
							end else begin
								fc_reg <= fc_reg + 8'h01;
							end
						end
					endcase
				end
			end

			// snapshot follows samples while sensing in normal or stop, the pin otherwise
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					snap_reg[i] <= 1'b0;
				end else if (cycOn[i] && awakeMode) begin
					if (sampDone[i]) begin
						snap_reg[i] <= smp_reg[i];
					end
				end else begin
					snap_reg[i] <= lvl_reg[i];
				end
			end
		end
	endgenerate

	// write strobes
	logic wrSrc;
	logic wrFlagsA;
	logic wrFlagsB;
	logic wrStat;
	assign wrSrc = wrStb && (addr == OFF_WAKE_SOURCE_ENABLE);
	assign wrFlagsA = wrStb && (addr == OFF_WAKE_FLAGS_A);
	assign wrFlagsB = wrStb && (addr == OFF_WAKE_FLAGS_B);
	assign wrStat = wrStb && (addr == OFF_FAULT_STATUS);

	// wake source and switch mapping registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			src_reg <= SRC_RESET;
			mapA_reg <= MAP_RESET;
			mapB_reg <= MAP_RESET;
		end else begin
			if (wrSrc) begin
				src_reg <= wrData[10:0];
			end
			if (wrStb && addr == OFF_HIGHSIDE_MAP_A) begin
				mapA_reg <= wrData[3:0];
			end
			if (wrStb && addr == OFF_HIGHSIDE_MAP_B) begin
				mapB_reg <= wrData[3:0];
			end
		end
	end

	// wake flags, write one to clear, a new event wins
	logic [2:0] wkSet;
	assign wkSet = cycEvt | statEvt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flagsA_reg <= 3'h0;
			flagsB_reg <= 2'h0;
		end else begin
			flagsA_reg <= (flagsA_reg & ~(wrFlagsA ? wrData[2:0] : 3'h0)) | wkSet;
			flagsB_reg <= (flagsB_reg & ~(wrFlagsB ? wrData[1:0] : 2'h0)) | tmrWake;
		end
	end

	// failure flag, sticky until written with one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			spiFail_reg <= 1'b0;
		end else begin
			spiFail_reg <= (spiFail_reg && !(wrStat && wrData[STAT_SPI_FAIL_BIT])) || (|tooLong);
		end
	end

	// interrupt and wake request pulses
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			intReq_n <= 1'b1;
			wakeRequest <= 1'b0;
		end else begin
			intReq_n <= !(awakeMode && ((|wkSet) || (|tmrWake)));
			// sleep with pending flags turns straight back
			wakeRequest <= ((|wkSet) && !awakeMode) ||
				(sleepReq && ((|flagsA_reg) || (|flagsB_reg)));
		end
	end

	// highside switches with fault shut-off
	genvar j;
	generate
		for (j = 0; j < NUM_HS; j++) begin : gHs
			logic [1:0] m;
			logic wrMap;
			assign m = hsMap[2 * j +: 2];
			assign wrMap = wrStb && (addr == ((j < 2) ? OFF_HIGHSIDE_MAP_A : OFF_HIGHSIDE_MAP_B));

			// fault latch, cleared by remapping the switch
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					hsOff_reg[j] <= 1'b0;
				end else if (hsFault[j] && !failSafe && m != HS_SRC_OFF) begin
					hsOff_reg[j] <= 1'b1;
				end else if (wrMap) begin
					hsOff_reg[j] <= 1'b0;
				end
			end

			// driver level from its selected source
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					highsideSwitch[j] <= 1'b0;
				end else if (failSafe || hsOff_reg[j]) begin
					highsideSwitch[j] <= 1'b0;
				end else if (m == HS_SRC_OFF) begin
					highsideSwitch[j] <= 1'b0;
				end else if (m == HS_SRC_ON) begin
					highsideSwitch[j] <= 1'b1;
				end else begin
					highsideSwitch[j] <= tmrLvl[m[0]];
				end
			end
		end
	endgenerate

	// read port, data one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData <= 16'h0000;
		end else if (rdStb) begin
			case (addr)
				OFF_FIRST_TIMER_SETUP: rdData <= {10'h000, setup_reg[0]};
				OFF_SECOND_TIMER_SETUP: rdData <= {10'h000, setup_reg[1]};
				OFF_HIGHSIDE_MAP_A: rdData <= {12'h000, mapA_reg};
				OFF_HIGHSIDE_MAP_B: rdData <= {12'h000, mapB_reg};
				OFF_WAKE_SOURCE_ENABLE: rdData <= {5'h00, src_reg};
				OFF_WAKE_FLAGS_A: rdData <= {13'h0000, flagsA_reg};
				OFF_WAKE_FLAGS_B: rdData <= {14'h0000, flagsB_reg};
				OFF_WAKE_LEVEL_SNAPSHOT: rdData <= {13'h0000, snap_reg};
				// fault shut-off [7:4], running [3:2], failure flag [0]
				OFF_FAULT_STATUS: rdData <= {8'h00, hsOff_reg, run_reg, 1'b0, spiFail_reg};
				default: rdData <= 16'h0000; // unmapped reads zero
			endcase
		end else begin
			rdData <= 16'h0000;
		end
	end
endmodule : cswt_timers

// File: design/cswt_pkg.sv
package cswt_pkg;
	// clock and time base
	localparam int CLK_NS = 100;
	localparam int TICK_NS = 100_000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	// settle window after each on-time, a least time so rounded up
	localparam int WAKE_FILTER_WINDOW_NS = 16_000;
	localparam int WAKE_FILTER_WINDOW_CYC = (WAKE_FILTER_WINDOW_NS + CLK_NS - 1) / CLK_NS;

	// period choices in 0.1 ms ticks: 10/20/50/100/200 ms, 1 s, 2 s (code 7 repeats 2 s)
	localparam logic [14:0] PERIOD_TICKS [0:7] = '{15'h0064, 15'h00C8, 15'h01F4, 15'h03E8,
		15'h07D0, 15'h2710, 15'h4E20, 15'h4E20};
	// on-time choices in ticks: off-low, off-high, 0.1/0.3/1.0/10/20 ms, code 7 repeats 20 ms
	localparam logic [14:0] ONTIME_TICKS [0:7] = '{15'h0000, 15'h0000, 15'h0001, 15'h0003,
		15'h000A, 15'h0064, 15'h00C8, 15'h00C8};
	localparam logic [2:0] ON_OFF_LOW = 3'h0;
	localparam logic [2:0] ON_OFF_HIGH = 3'h1;
	localparam logic [2:0] ON_FIRST_RUN = 3'h2;

	// register offsets (byte addresses)
	localparam logic [7:0] OFF_FIRST_TIMER_SETUP = 8'h00;
	localparam logic [7:0] OFF_SECOND_TIMER_SETUP = 8'h04;
	localparam logic [7:0] OFF_HIGHSIDE_MAP_A = 8'h08;
	localparam logic [7:0] OFF_HIGHSIDE_MAP_B = 8'h0C;
	localparam logic [7:0] OFF_WAKE_SOURCE_ENABLE = 8'h10;
	localparam logic [7:0] OFF_WAKE_FLAGS_A = 8'h14;
	localparam logic [7:0] OFF_WAKE_FLAGS_B = 8'h18;
	localparam logic [7:0] OFF_WAKE_LEVEL_SNAPSHOT = 8'h1C;
	localparam logic [7:0] OFF_FAULT_STATUS = 8'h20;

	// field positions
	localparam int SETUP_PERIOD_LSB = 0;
	localparam int SETUP_ONTIME_LSB = 3;
	localparam int SRC_STATIC_LSB = 6;
	localparam int SRC_TIMER_WAKE_LSB = 9;
	localparam int STAT_SPI_FAIL_BIT = 0;
	localparam int STAT_HS_OFF_LSB = 4;

	// reset values
	localparam logic [5:0] SETUP_RESET = 6'h00;
	localparam logic [3:0] MAP_RESET = 4'h0;
	localparam logic [10:0] SRC_RESET = 11'h000;

	// highside source selection per switch
	localparam logic [1:0] HS_SRC_OFF = 2'h0;
	localparam logic [1:0] HS_SRC_ON = 2'h1;

	// device operating mode, driven by the mode controller
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_STOP = 2'b01,
		MODE_SLEEP = 2'b10,
		MODE_FAILSAFE = 2'b11
	} cswt_mode_t;

	// per-input settle filter
	typedef enum logic {
		FILT_IDLE = 1'b0,
		FILT_WAIT = 1'b1
	} cswt_filt_t;
endpackage : cswt_pkg

// File: verification/cswt_props.sv
`timescale 1ns/1ps
module cswt_props (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] addr,
	input wire logic [15:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	input wire logic [15:0] rdData,
	// device context
	input wire cswt_pkg::cswt_mode_t mode,
	input wire logic sleepReq,
	input wire logic [2:0] wakeInput,
	input wire logic [3:0] hsFault,
	// outputs
	input wire logic [3:0] highsideSwitch,
	input wire logic intReq_n,
	input wire logic wakeRequest
);
	import cswt_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// read data only in the cycle after a read
	chk_read_idle: assert property (!$past(rdStb) |-> rdData == 16'h0000)
		else $error("read data outside its cycle");
	// interrupt is a single low cycle
	chk_int_single: assert property ($fell(intReq_n) |=> intReq_n)
		else $error("interrupt longer than one cycle");
	// wake request is a single high cycle
	chk_wake_single: assert property (wakeRequest |=> !wakeRequest)
		else $error("wake request longer than one cycle");
	// interrupts only come from normal or stop
	chk_int_mode: assert property (!intReq_n |-> $past(mode) inside {MODE_NORMAL, MODE_STOP})
		else $error("interrupt in a low power mode");
	// wake only from sleep, fail-safe or a refused sleep
	chk_wake_cause: assert property (wakeRequest |->
		($past(mode) inside {MODE_SLEEP, MODE_FAILSAFE}) || $past(sleepReq))
		else $error("wake request without cause");
	// fail-safe turns every switch off
	chk_failsafe_off: assert property ((mode == MODE_FAILSAFE) [*3] |-> highsideSwitch == 4'h0)
		else $error("switch on in fail-safe");
	// no cyclic interrupts once in fail-safe
	chk_failsafe_quiet: assert property ((mode == MODE_FAILSAFE) [*2] |-> intReq_n)
		else $error("interrupt in fail-safe");
	// one event is routed one way only
	chk_route_excl: assert property (!(!intReq_n && wakeRequest))
		else $error("interrupt and wake together");
	// a faulted switch is shut off
	for (genvar g = 0; g < 4; g++) begin : gFault
		chk_fault_shutoff: assert property (hsFault[g] [*3] |-> !highsideSwitch[g])
			else $error("switch stayed on under fault");
	end

	// main scenarios reached
	cover property ($fell(intReq_n));
	cover property (wakeRequest);
	cover property (highsideSwitch[0]);
endmodule : cswt_props

// File: verification/cswt_switch_net.sv
`timescale 1ns/1ps
module cswt_switch_net #(
	parameter int HOLD_CYC = 300
) (
	// clock
	input wire logic clk,
	// supply and contacts
	input wire logic [3:0] highsideSwitch,
	input wire logic [2:0] closed,
	// wake pins
	output logic [2:0] wakeInput
);
	int holdCnt [0:2] = '{0, 0, 0};  // decay counters
	logic [2:0] held = 3'h0;  // pin levels

	// input i is fed by switch i through contact i; a pin capacitor holds
	// the level briefly after the supply drops, then the pull-down wins
	always @(posedge clk) begin
		for (int i = 0; i < 3; i++) begin
			if (highsideSwitch[i]) begin
				held[i] <= closed[i];
				holdCnt[i] <= HOLD_CYC;
			end else if (holdCnt[i] > 0) begin
				holdCnt[i] <= holdCnt[i] - 1;
			end else begin
				held[i] <= 1'b0;
			end
		end
	end
	assign wakeInput = held;
endmodule : cswt_switch_net

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	import cswt_pkg::*;
	logic clk;  // system clock
	logic rst_n;  // reset
	logic [7:0] addr;  // bus address
	logic [15:0] wrData;  // bus write data
	logic wrStb;  // write strobe
	logic rdStb;  // read strobe
	logic [15:0] rdData;  // bus read data
	cswt_mode_t mode;  // device mode
	logic sleepReq;  // sleep request
	logic [2:0] wakeInput;  // wake pins
	logic [3:0] hsFault;  // switch faults
	logic [3:0] highsideSwitch;  // switch drive
	logic intReq_n;  // interrupt
	logic wakeRequest;  // wake request
	logic [2:0] closed;  // contact positions
	logic [15:0] got;  // read result
	logic [15:0] d;  // random value
	int errors = 0;
	int samples_checked = 0;
	int intSeen = 0;  // interrupt pulses
	int wakeSeen = 0;  // wake pulses
	int cycles = 0;  // run length
	int i;  // loop index

	cswt_timers uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb),
		.rdStb(rdStb), .rdData(rdData), .mode(mode), .sleepReq(sleepReq), .wakeInput(wakeInput),
		.hsFault(hsFault), .highsideSwitch(highsideSwitch), .intReq_n(intReq_n), .wakeRequest(wakeRequest));
	cswt_switch_net #(.HOLD_CYC(300)) net (.clk(clk), .highsideSwitch(highsideSwitch),
		.closed(closed), .wakeInput(wakeInput));

	// clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// verdict and end of run
	task automatic conclude;
		if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	// compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// idle cycles
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// one-cycle write
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wrData <= v;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
	endtask : wr
	// one-cycle read, data taken in the cycle after
	task automatic rdChk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] exp);
		@(posedge clk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		@(negedge clk);
		got = rdData;
		check(got & m, exp);
	endtask : rdChk
	// switch drive
	task automatic hsChk(input logic [3:0] exp);
		@(negedge clk);
		check({12'h000, highsideSwitch}, {12'h000, exp});
	endtask : hsChk

	// pulse counters and hang guard
	always @(posedge clk) begin
		cycles++;
		if (rst_n === 1'b1 && intReq_n === 1'b0) intSeen++;
		if (rst_n === 1'b1 && wakeRequest === 1'b1) wakeSeen++;
		if (cycles == 104000) begin  // one 10 ms period plus setup and fail-safe decay
			errors++;
			conclude();
		end
	end

	// main sequence
	initial begin
		rst_n = 1'b0;
		addr = 8'h00;
		wrData = 16'h0000;
		wrStb = 1'b0;
		rdStb = 1'b0;
		mode = MODE_NORMAL;
		sleepReq = 1'b0;
		hsFault = 4'h0;
		closed = 3'h0;
		void'($urandom(49));
		cyc(2);
		rst_n <= 1'b1;
		// reset values, last address unmapped
		for (i = 0; i <= 9; i++) rdChk(8'(i * 4), 16'hFFFF, 16'h0000);
		for (i = 0; i < 4; i++) begin
			d = 16'($urandom) & 16'h000F;
			wr(OFF_HIGHSIDE_MAP_B, d);
			rdChk(OFF_HIGHSIDE_MAP_B, 16'hFFFF, d);
		end
		wr(OFF_HIGHSIDE_MAP_B, 16'h0000);
		// idle level while stopped
		wr(OFF_HIGHSIDE_MAP_A, 16'h0002);
		wr(OFF_FIRST_TIMER_SETUP, 16'h0008);
		cyc(3);
		hsChk(4'h1);
		wr(OFF_FIRST_TIMER_SETUP, 16'h0000);
		cyc(3);
		hsChk(4'h0);
		// on-time longer than period
		wr(OFF_FIRST_TIMER_SETUP, 16'h0030);
		rdChk(OFF_FAULT_STATUS, 16'h000F, 16'h0005);
		wr(OFF_FIRST_TIMER_SETUP, 16'h0000);
		wr(OFF_FAULT_STATUS, 16'h0001);
		rdChk(OFF_FAULT_STATUS, 16'hFFFF, 16'h0000);
		// sensing plus cyclic wake on timer1, host order kept
		wr(OFF_WAKE_SOURCE_ENABLE, 16'h0201);
		closed <= 3'b001;
		wr(OFF_FIRST_TIMER_SETUP, 16'h0010);
		cyc(3);
		hsChk(4'h1);
		cyc(2100);
		hsChk(4'h0);
		rdChk(OFF_WAKE_LEVEL_SNAPSHOT, 16'hFFFF, 16'h0001);
		check(16'(intSeen), 16'h0000);
		cyc(1);
		closed <= 3'b000;
		mode <= MODE_STOP;  // second period runs in stop
		cyc(99200);
		check(16'(intSeen), 16'h0002);
		rdChk(OFF_WAKE_FLAGS_A, 16'hFFFF, 16'h0001);
		rdChk(OFF_WAKE_FLAGS_B, 16'hFFFF, 16'h0001);
		rdChk(OFF_WAKE_LEVEL_SNAPSHOT, 16'hFFFF, 16'h0000);
		// sleep refused with flags pending
		cyc(1);
		mode <= MODE_SLEEP;  // sensing was started in normal
		cyc(2);
		sleepReq <= 1'b1;
		cyc(1);
		sleepReq <= 1'b0;
		cyc(3);
		check(16'(wakeSeen), 16'h0001);
		mode <= MODE_NORMAL;
		wr(OFF_FIRST_TIMER_SETUP, 16'h0000);
		wr(OFF_WAKE_FLAGS_A, 16'h0007);
		wr(OFF_WAKE_FLAGS_B, 16'h0003);
		rdChk(OFF_WAKE_FLAGS_A, 16'hFFFF, 16'h0000);
		// pin change in sleep wakes instead of interrupting
		wr(OFF_HIGHSIDE_MAP_A, 16'h0004);
		wr(OFF_WAKE_SOURCE_ENABLE, 16'h0080);
		mode <= MODE_SLEEP;
		cyc(10);
		closed <= 3'b010;
		cyc(10);
		check(16'(wakeSeen), 16'h0002);
		check(16'(intSeen), 16'h0002);
		rdChk(OFF_WAKE_FLAGS_A, 16'hFFFF, 16'h0002);
		// fault shuts the switch, timer keeps going
		cyc(1);
		mode <= MODE_NORMAL;
		wr(OFF_FIRST_TIMER_SETUP, 16'h0010);
		hsFault <= 4'h2;
		cyc(4);
		hsFault <= 4'h0;
		cyc(3);
		hsChk(4'h0);
		rdChk(OFF_FAULT_STATUS, 16'h00FF, 16'h0024);
		wr(OFF_HIGHSIDE_MAP_A, 16'h0004);
		cyc(3);
		hsChk(4'h2);
		// fail-safe stops switches and timers
		cyc(1);
		mode <= MODE_FAILSAFE;
		cyc(5);
		hsChk(4'h0);
		rdChk(OFF_FAULT_STATUS, 16'h000C, 16'h0000);
		// pin decays once the switch is off, static sensing still wakes
		cyc(400);
		check(16'(wakeSeen), 16'h0003);
		check(16'(intSeen), 16'h0002);
		conclude();
	end
endmodule : testbench

bind cswt_timers cswt_props chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb),
	.rdStb(rdStb), .rdData(rdData), .mode(mode), .sleepReq(sleepReq), .wakeInput(wakeInput),
	.hsFault(hsFault), .highsideSwitch(highsideSwitch), .intReq_n(intReq_n), .wakeRequest(wakeRequest));
